// >>> pmac_top.v
// PHY management access control: AXI4-Lite registers and serial management engine
`timescale 1ns/1ps
`include "pmac_consts.vh"
module pmac_top (
  input wire clk_sys,
  input wire srst,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg mdc,
  output reg mdio_o,
  output reg mdio_oe,
  input wire mdio_i
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  localparam [1:0] RESP_OKAY = 2'h0;
  localparam [1:0] RESP_SLVERR = 2'h2;
  reg [4:0] phy_sel_r;
  reg [4:0] phy_register_selector_r;
  reg preamble_suppress_r;
  reg wr_dir_r;
  reg busy_r;
  reg [15:0] mgmt_data_r;
  reg aw_held_r;
  reg w_held_r;
  reg [11:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  wire mdio_in_s;

  // Engine state, one-hot
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_PRE = 4'h2;
  localparam [3:0] ST_FRAME = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;
  reg [3:0] state_r;
  reg [3:0] div_r;
  reg [5:0] bit_cnt_r;
  reg [31:0] shift_r;
  reg [15:0] rd_shift_r;
  reg start_r;

  // MDIO input is asynchronous to clk_sys
  pmac_sync2 u_mdio_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .din(mdio_i),
    .dout(mdio_in_s)
  );

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  // Byte lanes 1:0 of the address are ignored; compare at full width
  wire wr_ctrl = wr_go && ({aw_addr_r[11:2], 2'b00} == `PMAC_OFS_ADDR_CTRL);
  wire wr_data = wr_go && ({aw_addr_r[11:2], 2'b00} == `PMAC_OFS_DATA);

  // Address and data taken in either order; response after both
  always @(posedge clk_sys) begin
    if (srst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready;
      s_axi_wready <= !w_held_r && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_ctrl || wr_data) ? RESP_OKAY : RESP_SLVERR;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Register updates
  // ****************************************************************
  // Writes while busy are dropped, which makes the undefined case safe
  always @(posedge clk_sys) begin
    if (srst) begin
      phy_sel_r <= 5'h00;
      phy_register_selector_r <= 5'h00;
      preamble_suppress_r <= 1'b0;
      wr_dir_r <= 1'b0;
      busy_r <= 1'b0;
      mgmt_data_r <= `PMAC_DATA_RST;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (state_r[3]) begin
        busy_r <= 1'b0;
        if (!wr_dir_r) begin
          mgmt_data_r <= rd_shift_r;
        end
      end else if (wr_ctrl && !busy_r) begin
        if (w_strb_r[1]) begin
          phy_sel_r <= w_data_r[`PMAC_PHY_MSB:`PMAC_PHY_LSB];
        end
        if (w_strb_r[1] && w_strb_r[0]) begin
          phy_register_selector_r <= w_data_r[`PMAC_REG_MSB:`PMAC_REG_LSB];
        end
        if (w_strb_r[0]) begin
          preamble_suppress_r <= w_data_r[`PMAC_PRE_BIT];
          wr_dir_r <= w_data_r[`PMAC_WR_BIT];
          busy_r <= w_data_r[`PMAC_BUSY_BIT];
          start_r <= w_data_r[`PMAC_BUSY_BIT];
        end
      end else if (wr_data && !busy_r) begin
        if (w_strb_r[0]) begin
          mgmt_data_r[7:0] <= w_data_r[7:0];
        end
        if (w_strb_r[1]) begin
          mgmt_data_r[15:8] <= w_data_r[15:8];
        end
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  wire [31:0] ctrl_rd = {16'h0000, phy_sel_r, phy_register_selector_r, 3'h0,
    preamble_suppress_r, wr_dir_r, busy_r};

  always @(posedge clk_sys) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        if ({s_axi_araddr[11:2], 2'b00} == `PMAC_OFS_ADDR_CTRL) begin
          s_axi_rdata <= ctrl_rd;
        end else if ({s_axi_araddr[11:2], 2'b00} == `PMAC_OFS_DATA) begin
          s_axi_rdata <= {16'h0000, mgmt_data_r};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Serial management engine
  // ****************************************************************
  // One bit per mdc period; output changes at falling mdc, input read at rising
  wire tick_rise = (div_r == `PMAC_MDC_HALF - 4'h1) && !mdc;
  wire tick_fall = (div_r == `PMAC_MDC_HALF - 4'h1) && mdc;
  // Reads release the line from the first turnaround bit (count 18) on,
  // so the PHY never meets a driven line when it takes over
  wire in_read_phase = !wr_dir_r && (bit_cnt_r < 6'h13);

  always @(posedge clk_sys) begin
    if (srst) begin
      state_r <= ST_IDLE;
      div_r <= 4'h0;
      bit_cnt_r <= 6'h00;
      shift_r <= 32'h0000_0000;
      rd_shift_r <= 16'h0000;
      mdc <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
    end else begin
      if (!state_r[0] && !state_r[3]) begin
        div_r <= (div_r == `PMAC_MDC_HALF - 4'h1) ? 4'h0 : div_r + 4'h1;
        if (div_r == `PMAC_MDC_HALF - 4'h1) begin
          mdc <= !mdc;
        end
      end
      case (state_r)
        ST_IDLE: begin
          div_r <= 4'h0;
          mdc <= 1'b0;
          if (start_r) begin
            // Frame: 01, opcode, phy, reg, turnaround, data
            shift_r <= {2'b01, wr_dir_r ? 2'b01 : 2'b10, phy_sel_r,
              phy_register_selector_r, wr_dir_r ? 2'b10 : 2'b11, mgmt_data_r};
            if (preamble_suppress_r) begin
              state_r <= ST_FRAME;
              bit_cnt_r <= `PMAC_FRAME_BITS;
            end else begin
              state_r <= ST_PRE;
              bit_cnt_r <= `PMAC_PRE_BITS;
            end
            mdio_oe <= 1'b1;
            mdio_o <= 1'b1;
          end else begin
            mdio_oe <= 1'b0;
          end
        end
        ST_PRE: begin
          mdio_o <= 1'b1;
          if (tick_fall) begin
            bit_cnt_r <= bit_cnt_r - 6'h01;
            if (bit_cnt_r == 6'h01) begin
              state_r <= ST_FRAME;
              bit_cnt_r <= `PMAC_FRAME_BITS;
            end
          end
        end
        ST_FRAME: begin
          mdio_o <= shift_r[31];
          mdio_oe <= !in_read_phase;
          if (tick_rise && !wr_dir_r && bit_cnt_r <= 6'h10) begin
            rd_shift_r <= {rd_shift_r[14:0], mdio_in_s};
          end
          if (tick_fall) begin
            shift_r <= {shift_r[30:0], 1'b0};
            bit_cnt_r <= bit_cnt_r - 6'h01;
            if (bit_cnt_r == 6'h01) begin
              state_r <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
          mdio_oe <= 1'b0;
          mdc <= 1'b0;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // pmac_top

// >>> pmac_consts.vh
// Constants for the PHY management access control block
`ifndef PMAC_CONSTS_VH
`define PMAC_CONSTS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define PMAC_OFS_ADDR_CTRL 12'h414
`define PMAC_OFS_DATA 12'h418

// ****************************************************************
// Field positions of the address/control register
// ****************************************************************
`define PMAC_PHY_MSB 15
`define PMAC_PHY_LSB 11
`define PMAC_REG_MSB 10
`define PMAC_REG_LSB 6
`define PMAC_PRE_BIT 2
`define PMAC_WR_BIT 1
`define PMAC_BUSY_BIT 0

// ****************************************************************
// Reset values
// ****************************************************************
`define PMAC_ADDR_CTRL_RST 32'h0000_0000
`define PMAC_DATA_RST 16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define PMAC_MDC_HALF 4'h4
`define PMAC_PRE_BITS 6'h20
`define PMAC_FRAME_BITS 6'h20

`endif

// >>> pmac_sync2.v
// Two-stage synchroniser for one input from outside the clock domain
`timescale 1ns/1ps
module pmac_sync2 (
  input wire clk_sys,
  input wire srst,
  input wire din,
  output reg dout
);
  reg meta_r;

  // Only the second stage is read outside
  always @(posedge clk_sys) begin
    if (srst) begin
      meta_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // pmac_sync2

// >>> pmac_monitor.sv
// Assertion checker for the PHY management block
`timescale 1ns/1ps
module pmac_monitor (
  input wire clk_sys,
  input wire srst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire mdc,
  input wire mdio_o,
  input wire mdio_oe
);
  // ****
  // Port checks
  // ****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Management clock: four cycles per half
  sequence s_hi; mdc [*4] ##1 !mdc; endsequence
  property p_mdc_hi; $rose(mdc) |-> s_hi; endproperty
  a_mdc_hi: assert property (p_mdc_hi) else $error("mdc high phase");
  property p_mdc_lo; $fell(mdc) |-> !mdc [*4]; endproperty
  a_mdc_lo: assert property (p_mdc_lo) else $error("mdc low phase");
  // Data moves only as mdc falls, so it is settled when the PHY samples
  property p_hold; mdc && $past(mdc) |-> $stable(mdio_o); endproperty
  a_hold: assert property (p_hold) else $error("mdio moved");
  property p_rst; $fell(srst) |-> !mdc && !mdio_oe && !s_axi_bvalid && !s_axi_rvalid; endproperty
  a_rst: assert property (p_rst) else $error("not idle");
  property p_rzero; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_rzero: assert property (p_rzero) else $error("upper bits");
  property p_bresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid; endproperty
  a_bresp: assert property (p_bresp) else $error("no bvalid");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("no rvalid");
  property p_rone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rone: assert property (p_rone) else $error("rvalid stuck");
endmodule // pmac_monitor
bind pmac_top pmac_monitor pmac_monitor_inst (.*);

// >>> pmac_phy_model.sv
// Behavioural PHY on the management link
`timescale 1ns/1ps
module pmac_phy_model (
  input wire mdc,
  input wire mdio_o,
  input wire mdio_oe,
  input wire [15:0] rd_val,
  output logic phy_oe = 1'b0,
  output logic phy_o = 1'b1,
  output logic [5:0] pre_cnt,
  output logic [13:0] hdr,
  output logic [15:0] wdat
);
  logic [31:0] sh = '0;
  logic [5:0] pos = '0, run = '0;
  logic [4:0] cnt = '0;
  logic go = 1'b0;
  // Frame decoder, bits counted from the start bit
  always @(posedge mdc) begin
    sh <= {sh[30:0], mdio_o};
    go <= mdio_oe && pos == 6'd13 && sh[10:9] == 2'b10;
    if (mdio_oe && pos == 6'd13) hdr <= {sh[12:0], mdio_o};
    if (mdio_oe && pos == 6'd31) wdat <= {sh[14:0], mdio_o};
    if (mdio_oe && pos == 6'd0 && !mdio_o) pre_cnt <= run;
    if (mdio_oe && pos == 6'd0) run <= mdio_o ? run + 6'd1 : 6'd0;
    pos <= (mdio_oe && (pos != 6'd0 || !mdio_o) && pos != 6'd31) ? pos + 6'd1 : 6'd0;
  end
  // Read answer; released line falls back to its pull-up
  always @(negedge mdc) begin
    phy_oe <= cnt > 5'd1;
    phy_o <= cnt == 5'd18 ? 1'b0 : rd_val[4'(cnt - 5'd2)];
    cnt <= cnt != 5'd0 ? cnt - 5'd1 : (go ? 5'd18 : 5'd0);
  end
endmodule // pmac_phy_model

// >>> test_phy_management_access_control.sv
// Self-checking bench for the PHY management block
`timescale 1ns/1ps
module test_phy_management_access_control;
  logic clk_sys = 1'b0, srst = 1'b1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, mdc, mdio_o, mdio_oe, phy_oe, phy_o;
  logic [5:0] pre_cnt;
  logic [13:0] hdr;
  logic [15:0] wdat, rd_val = '0;
  logic [34:0] ex, expq[$];
  int failures = 0, cmp_count = 0, seed = 9390;
  // Shared line, pulled high when nobody drives it
  wire mdio_i = mdio_oe ? mdio_o : (phy_oe ? phy_o : 1'b1);
  always #25 clk_sys = ~clk_sys;
  pmac_top pmac_top_inst (.*);
  pmac_phy_model pmac_phy_model_inst (.*);
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tmo(input bit t);
    if (t) begin
      failures++;
      test_done;
    end
  endtask
  // Bus write; address and data offered together
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    @(posedge clk_sys);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 60);
    s_axi_bready <= 1'b0;
    tmo(n >= 60);
    chk(34'(s_axi_bresp), 34'(e));
  endtask
  // Bus read; bit 34 of the note asks for a compare
  task automatic axr(input logic [11:0] a, input logic [34:0] e, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    n = 0;
    expq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 60);
    q = s_axi_rdata;
    s_axi_rready <= 1'b0;
    tmo(n >= 60);
  endtask
  // Each returned word against the oldest note, compared only when the note has bit 34 set
  always @(posedge clk_sys) begin
    if (s_axi_rvalid && s_axi_rready && expq.size() > 0) begin
      ex = expq.pop_front();
      if (ex[34]) chk({s_axi_rresp, s_axi_rdata}, ex[33:0]);
    end
  end
  // ****
  // Stimulus
  // ****
  initial begin
    logic [31:0] q, wv;
    logic [15:0] d;
    logic [4:0] ph, rg;
    int n;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    axr(12'h414, 35'h4_0000_0000, q);
    axw(12'h414, 32'hffff_fffe, 2'h0);
    axr(12'h414, 35'h4_0000_ffc6, q);
    axw(12'h7fc, 32'h1, 2'h2);
    axr(12'h7fc, 35'h6_0000_0000, q);
    for (int i = 0; i < 4; i++) begin
      ph = 5'($random(seed));
      rg = 5'($random(seed));
      d = 16'($random(seed));
      rd_val <= 16'($random(seed));
      wv = {16'h0, ph, rg, 3'h0, i[1], i[0], 1'b0};
      axw(12'h418, {16'h0, d}, 2'h0);
      axw(12'h414, wv | 32'h1, 2'h0);
      axr(12'h414, {3'h4, wv | 32'h1}, q);
      axw(12'h418, {16'h0, ~d}, 2'h0); // Dropped while busy
      n = 0;
      do begin
        axr(12'h414, 35'h0, q);
        n++;
      end while (q[0] && n < 400);
      tmo(n >= 400);
      axr(12'h414, {3'h4, wv}, q);
      if (i[0]) begin
        chk(34'(wdat), 34'(d));
        axr(12'h418, {19'h4_0000, d}, q);
      end else begin
        axr(12'h418, {19'h4_0000, rd_val}, q);
      end
      chk(34'(pre_cnt), i[1] ? 34'h0 : 34'h20);
      chk(34'(hdr), {20'h0, 2'b01, i[0] ? 2'b01 : 2'b10, ph, rg});
      $display("test %0d done", i);
    end
    // Reset cut into a running frame must leave the port idle and cleared
    axw(12'h414, 32'h0000_ffc7, 2'h0);
    repeat (60) @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    chk(34'({mdc, mdio_oe}), 34'h0);
    axr(12'h414, 35'h4_0000_0000, q);
    axr(12'h418, 35'h4_0000_0000, q);
    $display("test reset done");
    test_done;
  end
endmodule // test_phy_management_access_control
